// *** core_status_trace_consts.svh ***
// constants for the core status and trace port
`ifndef CORE_STATUS_TRACE_CONSTS_SVH
`define CORE_STATUS_TRACE_CONSTS_SVH

// ****************************************************************
// status code encodings
// ****************************************************************
`define CODE_CONTINUE     4'h0
`define CODE_BEGIN_INSN   4'h1
`define CODE_RSVD_A       4'h2
`define CODE_USER_ENTRY   4'h3
`define CODE_MARKER       4'h4
`define CODE_BRANCH       4'h5
`define CODE_RSVD_B       4'h6
`define CODE_EXC_RETURN   4'h7
`define CODE_XFER_PREFIX  2'h2
`define CODE_EXCEPTION    4'hC
`define CODE_EMU_ENTRY    4'hD
`define CODE_STOPPED      4'hE
`define CODE_HALTED       4'hF

// ****************************************************************
// sizes, counts and reset values
// ****************************************************************
`define HOLD_MIN_TICKS    4'h2
`define TRACE_DATA_W      32
`define TRACE_FIFO_DEPTH  16
`define PIN_SYNC_RESET    7'h38

`endif

// *** core_status_trace_pkg.sv ***
// types shared by the core status and trace port
package core_status_trace_pkg;

    // ****************************************************************
    // core event kinds and sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        EV_CONTINUE,
        EV_BEGIN_INSN,
        EV_USER_ENTRY,
        EV_MARKER,
        EV_BRANCH,
        EV_EXC_RETURN
    } ev_kind_t;

    typedef enum logic {
        SEQ_RUN,
        SEQ_HOLD
    } seq_state_t;

endpackage : core_status_trace_pkg

// *** pin_sync.sv ***
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps

module pin_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // pins and their synchronised copy
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_r;

    // meta_r feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= RESET_VAL;
            sync_o <= RESET_VAL;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule : pin_sync

// *** trace_fifo.sv ***
// trace word fifo with valid and ready on both sides
`timescale 1ns/1ps

module trace_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // fill side
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    // drain side
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;
    logic             push;
    logic             pop;

    assign push = in_valid_i & in_ready_o;
    assign pop  = out_valid_o & out_ready_i;
    assign out_data_o = mem_r[rd_ptr_r];

    always_comb begin
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    // flags are registered from the next count so both stay honest
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_r    <= '0;
            rd_ptr_r    <= '0;
            count_r     <= '0;
            in_ready_o  <= 1'b0;
            out_valid_o <= 1'b0;
        end else begin
            wr_ptr_r    <= push ? wr_ptr_r + 1'b1 : wr_ptr_r;
            rd_ptr_r    <= pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
            count_r     <= count_nxt;
            in_ready_o  <= (count_nxt != DEPTH[AW:0]);
            out_valid_o <= (count_nxt != '0);
        end
    end

endmodule : trace_fifo

// *** core_status_trace_port.sv ***
// core status code, trace nibble and debug pin block
//
// Summary of operation
// - active output-float input floats every output driver
// - float acts combinationally, with no clock edge involved
// - scan operation overrides the float request
// - status clock out follows the core-rate clock and times the outputs
// - four-bit trace bus shows captured data and breakpoint status
// - status code changes only with the status clock, shows core state
// - codes 0,1,3,4,5,7 report execution events
// - codes 8 to B start a one to four byte trace transfer
// - codes C,D,E,F report exception, emulator entry, stopped, halted
// - codes C to F stand for several status-clock cycles
// - scan and background debug signals share the same pins
// - reset input starts reset exception handling and floats data bus
`timescale 1ns/1ps
`include "core_status_trace_consts.svh"

module core_status_trace_port #(
    parameter int         TRACE_W    = `TRACE_DATA_W,
    parameter int         FIFO_DEPTH = `TRACE_FIFO_DEPTH,
    parameter logic [3:0] HOLD_MIN   = `HOLD_MIN_TICKS
) (
    // clock and reset
    input  wire logic                              core_clk_i,
    input  wire logic                              rst_i,
    // core-rate clock from the pll
    input  wire logic                              pll_clk_i,
    // device pins
    input  wire logic                              output_float_n_i,
    input  wire logic                              debug_protocol_select_i,
    input  wire logic                              reset_in_n_i,
    input  wire logic                              wake_up_n_i,
    input  wire logic [2:0]                        shared_dbg_i,
    // core events
    input  wire logic                              ev_valid_i,
    input  wire core_status_trace_pkg::ev_kind_t   ev_kind_i,
    output logic                                   ev_ready_o,
    // core levels
    input  wire logic                              core_exception_i,
    input  wire logic                              core_emu_entry_i,
    input  wire logic                              core_stopped_i,
    input  wire logic                              core_halted_i,
    input  wire logic [3:0]                        brk_status_i,
    // trace words
    input  wire logic                              trace_valid_i,
    input  wire logic [TRACE_W-1:0]                trace_data_i,
    input  wire logic [1:0]                        trace_len_i,
    output logic                                   trace_ready_o,
    // serial debug return and data bus request
    input  wire logic                              bgd_dso_i,
    input  wire logic                              scan_tdo_i,
    input  wire logic                              data_bus_drive_i,
    // status pins
    output logic                                   status_clock_out_o,
    output logic                                   status_clock_out_oe_o,
    output logic [3:0]                             core_status_code_o,
    output logic                                   core_status_code_oe_o,
    output logic [3:0]                             trace_nibble_o,
    output logic                                   trace_nibble_oe_o,
    output logic                                   shared_dso_o,
    output logic                                   shared_dso_oe_o,
    output logic                                   data_bus_oe_o,
    // decoded debug pins and system requests
    output logic                                   scan_active_o,
    output logic [2:0]                             bgd_sig_o,
    output logic [2:0]                             scan_sig_o,
    output logic                                   core_reset_req_o,
    output logic                                   wake_req_o
);

    // ****************************************************************
    // pin synchronisers and status clock edge
    // ****************************************************************
    logic [6:0] pins_s;
    logic       pll_s;
    logic       rst_n_s;
    logic       wake_n_s;
    logic       bgd_sel_s;
    logic [2:0] shared_s;
    logic       pll_d_r;
    logic       tick;

    pin_sync #(
        .WIDTH     (7),
        .RESET_VAL (`PIN_SYNC_RESET)
    ) u_pin_sync (
        .clk_i   (core_clk_i),
        .rst_i   (rst_i),
        .async_i ({pll_clk_i, reset_in_n_i, wake_up_n_i,
                   debug_protocol_select_i, shared_dbg_i}),
        .sync_o  (pins_s)
    );

    assign pll_s     = pins_s[6];
    assign rst_n_s   = pins_s[5];
    assign wake_n_s  = pins_s[4];
    assign bgd_sel_s = pins_s[3];
    assign shared_s  = pins_s[2:0];

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pll_d_r <= 1'b0;
        end else begin
            pll_d_r <= pll_s;
        end
    end

    assign tick = pll_s & ~pll_d_r;

    // ****************************************************************
    // trace fifo
    // ****************************************************************
    localparam int FW = TRACE_W + 2;

    logic          fifo_valid;
    logic [FW-1:0] fifo_data;
    logic          start_xfer;

    trace_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_trace_fifo (
        .clk_i       (core_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (trace_valid_i),
        .in_data_i   ({trace_len_i, trace_data_i}),
        .in_ready_o  (trace_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_data),
        .out_ready_i (start_xfer)
    );

    // ****************************************************************
    // held states: exception, emulator entry, stopped, halted
    // ****************************************************************
    core_status_trace_pkg::seq_state_t state_r;
    core_status_trace_pkg::seq_state_t state_nxt;
    logic                              hold_req;
    logic [3:0]                        hold_code;
    logic [3:0]                        hold_cnt_r;

    // reset input wins, then halted, stopped, emulator, exception
    always_comb begin
        hold_req  = 1'b1;
        hold_code = `CODE_EXCEPTION;
        if (!rst_n_s) begin
            hold_code = `CODE_EXCEPTION;
        end else if (core_halted_i) begin
            hold_code = `CODE_HALTED;
        end else if (core_stopped_i) begin
            hold_code = `CODE_STOPPED;
        end else if (core_emu_entry_i) begin
            hold_code = `CODE_EMU_ENTRY;
        end else if (core_exception_i) begin
            hold_code = `CODE_EXCEPTION;
        end else begin
            hold_req = 1'b0;
        end
    end

    // a held code stands at least HOLD_MIN status clocks
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            core_status_trace_pkg::SEQ_RUN: begin
                if (tick && hold_req) begin
                    state_nxt = core_status_trace_pkg::SEQ_HOLD;
                end
            end
            core_status_trace_pkg::SEQ_HOLD: begin
                if (tick && !hold_req && hold_cnt_r >= HOLD_MIN - 4'h1) begin
                    state_nxt = core_status_trace_pkg::SEQ_RUN;
                end
            end
            default: begin
                state_nxt = core_status_trace_pkg::SEQ_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_r <= core_status_trace_pkg::SEQ_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            hold_cnt_r <= 4'h0;
        end else if (tick) begin
            if (state_r != core_status_trace_pkg::SEQ_HOLD) begin
                hold_cnt_r <= 4'h0;
            end else if (hold_cnt_r != 4'hF) begin
                hold_cnt_r <= hold_cnt_r + 4'h1;
            end
        end
    end

    // ****************************************************************
    // pending execution event
    // ****************************************************************
    logic                            ev_pend_r;
    logic                            ev_pend_nxt;
    core_status_trace_pkg::ev_kind_t ev_kind_r;
    logic                            ev_take;
    logic [3:0]                      ev_code;
    logic [3:0]                      nib_left_r;

    assign start_xfer = tick && state_nxt == core_status_trace_pkg::SEQ_RUN
                        && fifo_valid && nib_left_r == 4'h0;
    assign ev_take    = tick && state_nxt == core_status_trace_pkg::SEQ_RUN
                        && !start_xfer && ev_pend_r;

    // a new event in the take cycle is refused by ev_ready_o, not lost
    always_comb begin
        ev_pend_nxt = ev_pend_r;
        if (ev_valid_i && ev_ready_o) begin
            ev_pend_nxt = 1'b1;
        end else if (ev_take) begin
            ev_pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ev_pend_r  <= 1'b0;
            ev_ready_o <= 1'b0;
            ev_kind_r  <= core_status_trace_pkg::EV_CONTINUE;
        end else begin
            ev_pend_r  <= ev_pend_nxt;
            ev_ready_o <= ~ev_pend_nxt;
            if (ev_valid_i && ev_ready_o) begin
                ev_kind_r <= ev_kind_i;
            end
        end
    end

    always_comb begin
        case (ev_kind_r)
            core_status_trace_pkg::EV_CONTINUE:   ev_code = `CODE_CONTINUE;
            core_status_trace_pkg::EV_BEGIN_INSN: ev_code = `CODE_BEGIN_INSN;
            core_status_trace_pkg::EV_USER_ENTRY: ev_code = `CODE_USER_ENTRY;
            core_status_trace_pkg::EV_MARKER:     ev_code = `CODE_MARKER;
            core_status_trace_pkg::EV_BRANCH:     ev_code = `CODE_BRANCH;
            core_status_trace_pkg::EV_EXC_RETURN: ev_code = `CODE_EXC_RETURN;
            default:                              ev_code = `CODE_CONTINUE;
        endcase
    end

    // ****************************************************************
    // status code and trace nibble outputs
    // ****************************************************************
    logic [TRACE_W-1:0] shift_r;
    logic [1:0]         xfer_len;

    assign xfer_len = fifo_data[FW-1:FW-2];

    // the status code and trace nibble move only on a status clock edge
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            core_status_code_o <= `CODE_CONTINUE;
        end else if (tick) begin
            if (state_nxt == core_status_trace_pkg::SEQ_HOLD) begin
                if (hold_req) begin
                    core_status_code_o <= hold_code;
                end
            end else if (start_xfer) begin
                core_status_code_o <= {`CODE_XFER_PREFIX, xfer_len};
            end else if (ev_pend_r) begin
                core_status_code_o <= ev_code;
            end else begin
                core_status_code_o <= `CODE_CONTINUE;
            end
        end
    end

    // low nibble first; idle cycles show breakpoint status
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            shift_r        <= '0;
            nib_left_r     <= 4'h0;
            trace_nibble_o <= 4'h0;
        end else if (tick) begin
            if (start_xfer) begin
                shift_r        <= fifo_data[TRACE_W-1:0];
                nib_left_r     <= {1'b0, xfer_len, 1'b0} + 4'h2;
                trace_nibble_o <= brk_status_i;
            end else if (nib_left_r != 4'h0) begin
                shift_r        <= shift_r >> 4;
                nib_left_r     <= nib_left_r - 4'h1;
                trace_nibble_o <= shift_r[3:0];
            end else begin
                trace_nibble_o <= brk_status_i;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            status_clock_out_o <= 1'b0;
        end else begin
            status_clock_out_o <= pll_s;
        end
    end

    // ****************************************************************
    // shared debug pins, reset and wake
    // ****************************************************************
    logic pins_oe_r;
    logic data_bus_oe_r;
    logic float_now;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            scan_active_o <= 1'b0;
            bgd_sig_o     <= 3'h0;
            scan_sig_o    <= 3'h0;
            shared_dso_o  <= 1'b0;
        end else begin
            scan_active_o <= ~bgd_sel_s;
            bgd_sig_o     <= bgd_sel_s ? shared_s : 3'h0;
            scan_sig_o    <= bgd_sel_s ? 3'h0 : shared_s;
            shared_dso_o  <= bgd_sel_s ? bgd_dso_i : scan_tdo_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pins_oe_r        <= 1'b0;
            data_bus_oe_r    <= 1'b0;
            core_reset_req_o <= 1'b0;
            wake_req_o       <= 1'b0;
        end else begin
            pins_oe_r        <= 1'b1;
            data_bus_oe_r    <= data_bus_drive_i & rst_n_s;
            core_reset_req_o <= ~rst_n_s;
            wake_req_o       <= ~wake_n_s;
        end
    end

    // float gates the enables with no flop, so it works without a clock;
    // only the static protocol select is synchronised
    assign float_now = ~output_float_n_i & bgd_sel_s;

    assign status_clock_out_oe_o = pins_oe_r & ~float_now;
    assign core_status_code_oe_o = pins_oe_r & ~float_now;
    assign trace_nibble_oe_o     = pins_oe_r & ~float_now;
    assign shared_dso_oe_o       = pins_oe_r & ~float_now;
    assign data_bus_oe_o         = data_bus_oe_r & ~float_now;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_float_drivers: assert property (
        (!output_float_n_i && bgd_sel_s) |->
        !core_status_code_oe_o && !trace_nibble_oe_o && !data_bus_oe_o
        && !status_clock_out_oe_o && !shared_dso_oe_o)
        else $error("output float did not release drivers");

    a_float_release: assert property (
        $rose(output_float_n_i) && pins_oe_r |-> core_status_code_oe_o)
        else $error("float release waited for a clock");

    a_scan_override: assert property (
        !bgd_sel_s && pins_oe_r |-> trace_nibble_oe_o && shared_dso_oe_o)
        else $error("float acted during scan operation");

    a_code_sync_tick: assert property (
        !tick |=> $stable(core_status_code_o) && $stable(trace_nibble_o))
        else $error("status output moved off the status clock");

    a_no_reserved: assert property (
        core_status_code_o != `CODE_RSVD_A
        && core_status_code_o != `CODE_RSVD_B)
        else $error("reserved status code driven");

    a_xfer_announce: assert property (
        start_xfer |=> core_status_code_o == {`CODE_XFER_PREFIX, $past(xfer_len)}
        && nib_left_r == {1'b0, $past(xfer_len), 1'b0} + 4'h2)
        else $error("transfer start code or length wrong");

    a_hold_min: assert property (
        state_r == core_status_trace_pkg::SEQ_HOLD
        && state_nxt == core_status_trace_pkg::SEQ_RUN
        |-> hold_cnt_r >= HOLD_MIN - 4'h1 && !hold_req)
        else $error("held status code left too early");

    a_reset_float_bus: assert property (
        !rst_n_s |=> !data_bus_oe_o && core_reset_req_o)
        else $error("reset input did not float the data bus");

    a_clk_follow: assert property (
        ##1 status_clock_out_o == $past(pll_s))
        else $error("status clock out lost the pll clock");

    a_halt_code: assert property (
        tick && rst_n_s && core_halted_i |=> core_status_code_o == `CODE_HALTED)
        else $error("halted code not shown");

    a_shared_route: assert property (
        ##1 scan_sig_o == ($past(bgd_sel_s) ? 3'h0 : $past(shared_s)))
        else $error("shared pin routed to the wrong protocol");

    c_hold_entry: cover property (
        state_r == core_status_trace_pkg::SEQ_RUN
        && state_nxt == core_status_trace_pkg::SEQ_HOLD);
    c_four_byte: cover property (start_xfer && xfer_len == 2'h3);
    c_float: cover property (float_now && pins_oe_r);
    c_event_out: cover property (ev_take && ev_kind_r
        == core_status_trace_pkg::EV_BRANCH);

endmodule : core_status_trace_port

// *** trace_capture.sv ***
// capture model that watches the status pins once per status tick
`timescale 1ns/1ps
module trace_capture (
    // status pins
    input  wire logic       status_clock_i,
    input  wire logic [3:0] code_i,
    // reserved code seen
    output logic            bad_code_o
);
    initial bad_code_o = 1'b0;
    // reserved codes are only ever a fault of the sender; the code moves
    // on the rising edge, so look on the falling one to avoid a race
    always @(negedge status_clock_i) begin
        if (code_i === 4'h2 || code_i === 4'h6) bad_code_o <= 1'b1;
    end
endmodule : trace_capture

// *** testbench.sv ***
// self-checking bench for the core status and trace port
`timescale 1ns/1ps
module testbench;
    logic        core_clk_i, rst_i, pll, fl_n, sel, rst_n, wake_n, ev_v;
    logic        exc, halt, t_v, drv, ev_rdy, t_rdy, sclk, c_oe, s_oe;
    logic        n_oe, d_oe, b_oe, scan, rreq, wreq, bad, emu, stp, dso;
    logic [3:0]  code, nib;
    logic [2:0]  shd, bsig, ssig;
    logic [31:0] td;
    logic [1:0]  tl;
    realtime     t0;
    int          errors, cmp_count;
    core_status_trace_pkg::ev_kind_t kind;

    core_status_trace_port dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .pll_clk_i(pll), .output_float_n_i(fl_n),
        .debug_protocol_select_i(sel), .reset_in_n_i(rst_n),
        .wake_up_n_i(wake_n), .shared_dbg_i(shd), .ev_valid_i(ev_v),
        .ev_kind_i(kind), .ev_ready_o(ev_rdy), .core_exception_i(exc),
        .core_emu_entry_i(emu), .core_stopped_i(stp),
        .core_halted_i(halt), .brk_status_i(4'h6), .trace_valid_i(t_v),
        .trace_data_i(td), .trace_len_i(tl), .trace_ready_o(t_rdy),
        .bgd_dso_i(1'b0), .scan_tdo_i(1'b1), .data_bus_drive_i(drv),
        .status_clock_out_o(sclk), .status_clock_out_oe_o(s_oe),
        .core_status_code_o(code), .core_status_code_oe_o(c_oe),
        .trace_nibble_o(nib), .trace_nibble_oe_o(n_oe),
        .shared_dso_o(dso), .shared_dso_oe_o(d_oe), .data_bus_oe_o(b_oe),
        .scan_active_o(scan), .bgd_sig_o(bsig), .scan_sig_o(ssig),
        .core_reset_req_o(rreq), .wake_req_o(wreq));
    trace_capture cap_u (.status_clock_i(sclk), .code_i(code),
        .bad_code_o(bad));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task step;
        @(posedge core_clk_i);
        #2;
    endtask : step
    task check(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task wait_code(input logic [3:0] exp);
        for (int i = 0; i < 60 && code !== exp; i++) step();
        check("status code", {28'h0, code}, {28'h0, exp});
    endtask : wait_code
    task tick;
        @(posedge sclk);
        #1;
    endtask : tick
    task stop_test;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task events;
        logic [3:0] exp [6] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h7};
        for (int k = 0; k < 6; k++) begin
            step();
            while (ev_rdy !== 1'b1) step();
            ev_v = 1'b1;
            kind = core_status_trace_pkg::ev_kind_t'(k);
            step();
            ev_v = 1'b0;
            wait_code(exp[k]);
        end
    endtask : events
    task traces;
        for (int l = 0; l < 4; l++) begin
            while (t_rdy !== 1'b1) step();
            {t_v, td, tl} = {1'b1, 32'h87654321, 2'(l)};
            step();
            t_v = 1'b0;
            wait_code(4'h8 + 4'(l));
            for (int n = 0; n < 2 * (l + 1); n++) begin
                tick();
                check("nibble", {28'h0, nib}, 32'(4'(td >> (4 * n))));
            end
        end
    endtask : traces
    task held;
        exc = 1'b1;
        wait_code(4'hC);
        {exc, emu} = 2'b01;
        wait_code(4'hD);
        {emu, stp} = 2'b01;
        wait_code(4'hE);
        {stp, halt} = 2'b01;
        wait_code(4'hF);
        tick();
        check("held code", {28'h0, code}, 32'hF);
        halt = 1'b0;
        t0 = $realtime;
        tick();
        check("status period", 32'($rtoi($realtime - t0)), 32'd400);
    endtask : held
    task pins;
        check("bgd route", {25'h0, bsig, ssig, dso}, 32'h50);
        fl_n = 1'b0;
        #1;
        check("float", {s_oe, c_oe, n_oe, d_oe, b_oe}, 32'h0);
        step();
        fl_n = 1'b1;
        sel = 1'b0;
        repeat (4) step();
        check("scan", {31'h0, scan}, 32'h1);
        check("scan route", {25'h0, bsig, ssig, dso}, 32'h0B);
        fl_n = 1'b0;
        #1;
        check("float scan", {s_oe, c_oe, n_oe, d_oe, b_oe}, 32'h1F);
        step();
        {fl_n, sel, rst_n, wake_n} = 4'h8;
        repeat (4) step();
        check("reset pin", {b_oe, rreq, wreq}, 32'h3);
        wait_code(4'hC);
        {sel, rst_n, wake_n} = 3'h7;
        repeat (4) step();
    endtask : pins

    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    initial begin
        pll = 1'b0;
        #7;
        forever #200 pll = ~pll;
    end
    initial begin
        #2_000_000;
        errors++;
        stop_test();
    end
    initial begin
        {rst_i, fl_n, sel, rst_n, wake_n, drv} = 6'h3F;
        {ev_v, exc, emu, stp, halt, t_v, td, tl} = '0;
        shd = 3'h5;
        kind = core_status_trace_pkg::EV_CONTINUE;
        {errors, cmp_count} = '0;
        repeat (5) @(posedge core_clk_i);
        #2;
        rst_i = 1'b0;
        repeat (2) step();
        events();
        traces();
        held();
        pins();
        check("reserved code", {31'h0, bad}, 32'h0);
        stop_test();
    end
endmodule : testbench
